// *** src/wdt_defines.svh ***
// register offsets, field positions, reset values and timing counts for the watchdog
`ifndef WDT_DEFINES_SVH
`define WDT_DEFINES_SVH
`define ADDR_WATCHDOG_CONTROL   4'h0
`define ADDR_RESET_CAUSE_FLAGS  4'h4
`define ADDR_SLEEP_CONTROL      4'h8
`define ADDR_WATCHDOG_STATUS    4'hC
`define WATCHDOG_CONTROL_RESET              8'h53
`define GEN_MSB                 7
`define GEN_LSB                 3
`define PSEL_MSB                2
`define PSEL_LSB                0
`define GEN_DISABLE             5'h15
`define GEN_ENABLE              5'h0A
`define FAULT_BIT               0
`define FAULT_DELAY_EDGES       2'h2
`define CNT_W                   19
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`define SLOW_DIV_DEFAULT        6104
`define RC_DIV_DEFAULT          6250
`endif

// *** src/wdt_pkg.sv ***
// types shared by the watchdog design files
package wdt_pkg;
  // sleep state of the core as seen by the watchdog, gray ordered
  typedef enum logic [1:0]
  {
    PM_RUN   = 2'b00,
    PM_IDLE  = 2'b01,
    PM_LIGHT = 2'b11,
    PM_DEEP  = 2'b10
  } pm_state_t;
endpackage

// *** src/wdt_slow_tick.sv ***
// slow clock enable generator: divides the fast clock down to two slow sources, the crystal one only when selected
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
module wdt_slow_tick
#(
  parameter int XTAL_DIV = `SLOW_DIV_DEFAULT,
  parameter int RC_DIV   = `RC_DIV_DEFAULT
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic src_sel_xtal,
  output logic      xtal_tick,
  output logic      rc_tick
);
  logic [15:0] xtal_cnt_r;   // crystal divider
  logic [15:0] rc_cnt_r;     // rc divider, always runs for the fault delay
  wire         xtal_end = (xtal_cnt_r == 16'(XTAL_DIV - 1));
  wire         rc_end   = (rc_cnt_r == 16'(RC_DIV - 1));

  // free-running dividers; the crystal one idles when not chosen to save toggling
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      xtal_cnt_r <= 16'h0000;
      rc_cnt_r   <= 16'h0000;
      xtal_tick  <= 1'b0;
      rc_tick    <= 1'b0;
    end
    else
    begin
      xtal_cnt_r <= (xtal_end || !src_sel_xtal) ? 16'h0000 : xtal_cnt_r + 16'h0001;
      rc_cnt_r   <= rc_end ? 16'h0000 : rc_cnt_r + 16'h0001;
      xtal_tick  <= xtal_end && src_sel_xtal;
      rc_tick    <= rc_end;
    end
  end
endmodule
`default_nettype wire

// *** src/wdt_top.sv ***
// watchdog timer with guarded enable field, reset request logic and axi4-lite registers
//
// Chosen here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
// register map, one 32-bit word per register, byte addresses
//   0x0 watchdog_control: enable code [7:3], period code [2:0]
//   0x4 reset_cause_flags: fault flag [0], writing 0 clears it
//   0x8 not decoded: zero data and an error response
//   0xC status, read only: count [18:0], expiry [19], enabled [20],
//       power state [22:21]
// the control register is reloaded only by RESET_N; the reset requests
// raised here leave it alone, so a bad code keeps asking for resets
// every rc tick until software writes a legal code again
// the core is expected to act on DEVICE_RESET_REQ and PC_SP_RESET;
// this block does not reset itself from them
// the slow rates are enables from one divider module, not clocks, so the
// whole block stays in the REF_CLK domain and needs no synchronisers
// limitation: the bad-code delay is measured in rc ticks even when the
//   crystal drives the count, since the rc source always runs
module wdt_top
  import wdt_pkg::*;
#(
  parameter int XTAL_DIV = `SLOW_DIV_DEFAULT,  // 200 MHz / 32.768 kHz
  parameter int RC_DIV   = `RC_DIV_DEFAULT     // 200 MHz / 32 kHz
)
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET_N,
  input  wire logic        SLOW_SRC_XTAL,      // configuration option, held static
  input  wire logic        CLEAR_WDT_INSN,     // one-cycle pulse from the core
  input  wire logic        HALT_INSN,          // one-cycle pulse from the core
  input  wire logic        HALT_DEEP,          // qualifies halt: deepest sleep
  input  wire logic        HALT_IDLE,          // qualifies halt: idle rather than light sleep
  input  wire logic        WAKE,               // core leaves sleep or idle
  output logic             DEVICE_RESET_REQ,
  output logic             PC_SP_RESET,
  output logic             EXPIRY_FLAG,
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  logic [7:0]         watchdog_control_r;          // watchdog_control register
  logic               fault_r;         // watchdog_ctrl_fault_flag
  logic               expiry_r;        // expiry_flag
  logic [`CNT_W-1:0]  cnt_r;           // slow tick counter
  pm_state_t          pm_r;            // core power state
  logic [1:0]         fault_cnt_r;     // rc edges seen since bad code
  logic               rst_req_r;       // full reset request
  logic               pcsp_r;          // partial reset pulse
  logic               aw_hold_r;       // write address latched
  logic               w_hold_r;        // write data latched
  logic [3:0]         awaddr_r;
  logic [31:0]        wdata_r;
  logic [3:0]         wstrb_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic               rvalid_r;
  logic [31:0]        rdata_r;
  logic [1:0]         rresp_r;
  logic               xtal_tick;
  logic               rc_tick;

  // slow clock enables from one divider module; both rates are single-cycle
  // pulses in the REF_CLK domain
  wdt_slow_tick #(.XTAL_DIV(XTAL_DIV), .RC_DIV(RC_DIV)) u_tick
  (
    .clk          (REF_CLK),
    .rst_n        (RESET_N),
    .src_sel_xtal (SLOW_SRC_XTAL),
    .xtal_tick    (xtal_tick),
    .rc_tick      (rc_tick)
  );

  // field decode; anything but the two legal enable codes counts as bad
  // the slow source follows the static configuration pin
  wire [4:0] gen_field  = watchdog_control_r[`GEN_MSB:`GEN_LSB];
  wire [2:0] psel_field = watchdog_control_r[`PSEL_MSB:`PSEL_LSB];
  wire       wdt_on     = (gen_field == `GEN_ENABLE);
  wire       gen_bad    = !wdt_on && (gen_field != `GEN_DISABLE);
  wire       slow_tick  = SLOW_SRC_XTAL ? xtal_tick : rc_tick;
  wire       counting   = wdt_on && (pm_r != PM_DEEP);

  // period code to overflow bit position; the steps are uneven, two bits
  // apart for the short periods and one bit apart from code 100 on
  function automatic logic [4:0] period_bit(input logic [2:0] code);
    case (code)
      3'h0:    period_bit = 5'h08;
      3'h1:    period_bit = 5'h0A;
      3'h2:    period_bit = 5'h0C;
      3'h3:    period_bit = 5'h0E;
      3'h4:    period_bit = 5'h0F;
      3'h5:    period_bit = 5'h10;
      3'h6:    period_bit = 5'h11;
      default: period_bit = 5'h12;
    endcase
  endfunction

  wire [`CNT_W-1:0] limit    = `CNT_W'(1) << period_bit(psel_field);
  wire [`CNT_W-1:0] cnt_inc  = cnt_r + `CNT_W'(1);
  wire              overflow = counting && slow_tick && (cnt_inc == limit);
  wire              halt_clr = HALT_INSN && (pm_r == PM_RUN);
  // an invalid code clears the counter too, since it is the start of a reset
  wire              cnt_clr  = CLEAR_WDT_INSN || halt_clr || gen_bad;

  // sleep state entered by a halt: deep wins over idle, light is what is left
  // the qualifiers are only looked at on the halt edge itself
  pm_state_t        halt_state;
  assign halt_state = HALT_DEEP ? PM_DEEP : (HALT_IDLE ? PM_IDLE : PM_LIGHT);

  // bus handshake decode; a half that arrives alone is parked in a holding
  // register, and the write happens on the edge that sees both halves
  // only the low byte lane carries register bits, so wstrb[0] gates writes
  wire aw_ok   = aw_hold_r || S_AXI_AWVALID;
  wire w_ok    = w_hold_r || S_AXI_WVALID;
  wire wr_go   = aw_ok && w_ok && !bvalid_r;
  wire [3:0]  wr_addr = aw_hold_r ? awaddr_r : S_AXI_AWADDR;
  wire [31:0] wr_data = w_hold_r ? wdata_r : S_AXI_WDATA;
  wire [3:0]  wr_strb = w_hold_r ? wstrb_r : S_AXI_WSTRB;
  wire wr_ctl  = wr_go && (wr_addr == `ADDR_WATCHDOG_CONTROL) && wr_strb[0];
  wire wr_flg  = wr_go && (wr_addr == `ADDR_RESET_CAUSE_FLAGS) && wr_strb[0];
  wire wr_map  = (wr_addr == `ADDR_WATCHDOG_CONTROL) || (wr_addr == `ADDR_RESET_CAUSE_FLAGS) ||
                 (wr_addr == `ADDR_WATCHDOG_STATUS);
  wire rd_go   = S_AXI_ARVALID && !rvalid_r;
  wire fault_set = gen_bad && rc_tick && (fault_cnt_r == `FAULT_DELAY_EDGES);

  assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
  assign S_AXI_WREADY  = !w_hold_r && !bvalid_r;
  assign S_AXI_ARREADY = !rvalid_r;
  assign S_AXI_BVALID  = bvalid_r;
  assign S_AXI_BRESP   = bresp_r;
  assign S_AXI_RVALID  = rvalid_r;
  assign S_AXI_RDATA   = rdata_r;
  assign S_AXI_RRESP   = rresp_r;
  assign DEVICE_RESET_REQ = rst_req_r;
  assign PC_SP_RESET   = pcsp_r;
  assign EXPIRY_FLAG   = expiry_r;

  // control register; the core's own reset does not touch these, only RESET_N
  // a write with the low strobe clear leaves it as it was
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      watchdog_control_r <= `WATCHDOG_CONTROL_RESET;
    else if (wr_ctl)
      watchdog_control_r <= wr_data[7:0];
  end

  // fault flag: hardware set beats a simultaneous software clear
  // writing 1 to the flag has no effect; only a zero clears it
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      fault_r <= 1'b0;
    else if (fault_set)
      fault_r <= 1'b1;
    else if (wr_flg && !wr_data[`FAULT_BIT])
      fault_r <= 1'b0;
  end

  // bad-code delay: reset on the third rc tick after the code turns bad,
  // which lands two to three rc periods later depending on divider phase
  // the count saturates, so a code left bad asks again on every tick
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N || !gen_bad)
      fault_cnt_r <= 2'h0;
    else if (rc_tick && fault_cnt_r != `FAULT_DELAY_EDGES)
      fault_cnt_r <= fault_cnt_r + 2'h1;
  end

  // counter with clear priority over counting; a clear and a slow tick on the
  // same edge leave it at zero, so a clear always buys a full period
  // overflow restarts it from zero in the same edge
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N || cnt_clr || overflow || (HALT_INSN && pm_r == PM_RUN))
      cnt_r <= '0;
    else if (counting && slow_tick)
      cnt_r <= cnt_inc;
  end

  // power state tracking; halt with the deep qualifier stops the count
  // a halt while already asleep is ignored, and an overflow asleep wakes
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      pm_r <= PM_RUN;
    else if (halt_clr)
      pm_r <= halt_state;
    else if (WAKE || (overflow && pm_r != PM_RUN))
      pm_r <= PM_RUN;
    else
      pm_r <= pm_r;
  end

  // reset requests: a bad enable code or a running overflow asks for a full reset,
  // an overflow while asleep only restarts the program counter and stack pointer
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      rst_req_r <= 1'b0;
      pcsp_r    <= 1'b0;
    end
    else
    begin
      rst_req_r <= fault_set || (overflow && pm_r == PM_RUN);
      pcsp_r    <= overflow && pm_r != PM_RUN;
    end
  end

  // expiry flag: an overflow sets it, a halt from run clears it; set wins a tie
  // so a timeout that lands on the halt edge is never lost
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      expiry_r <= 1'b0;
    else if (overflow)
      expiry_r <= 1'b1;
    else if (halt_clr)
      expiry_r <= 1'b0;
  end

  // write address holding register: kept when the address comes before its data
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      aw_hold_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end
    else if (wr_go)
      aw_hold_r <= 1'b0;
    else if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      aw_hold_r <= 1'b1;
      awaddr_r  <= S_AXI_AWADDR;
    end
  end

  // write data holding register: kept when the data come before their address
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      w_hold_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end
    else if (wr_go)
      w_hold_r <= 1'b0;
    else if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      w_hold_r <= 1'b1;
      wdata_r  <= S_AXI_WDATA;
      wstrb_r  <= S_AXI_WSTRB;
    end
  end

  // write response: raised the edge after both halves are in, held until bready
  // the status word accepts a write and ignores it, only undecoded offsets are refused
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      bvalid_r <= 1'b0;
      bresp_r  <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_r <= 1'b1;
      bresp_r  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (S_AXI_BREADY)
      bvalid_r <= 1'b0;
  end

  // read word selection; undecoded offsets read as zero with an error response
  wire        rd_ctl   = (S_AXI_ARADDR == `ADDR_WATCHDOG_CONTROL);
  wire        rd_flg   = (S_AXI_ARADDR == `ADDR_RESET_CAUSE_FLAGS);
  wire        rd_sts   = (S_AXI_ARADDR == `ADDR_WATCHDOG_STATUS);
  wire        rd_map   = rd_ctl || rd_flg || rd_sts;
  wire [31:0] ctl_word = {24'h000000, watchdog_control_r};
  wire [31:0] flg_word = {31'h0, fault_r};
  wire [31:0] sts_word = {9'h000, pm_r, wdt_on, expiry_r, cnt_r};
  wire [31:0] rd_word  = rd_ctl ? ctl_word : (rd_flg ? flg_word : (rd_sts ? sts_word : 32'h0000_0000));

  // read data register: loaded with the address, so the word is a snapshot of that edge
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end
    else if (rd_go)
    begin
      rdata_r <= rd_word;
      rresp_r <= rd_map ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // read valid: one cycle after the address, held until rready
  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
      rvalid_r <= 1'b0;
    else if (rd_go)
      rvalid_r <= 1'b1;
    else if (S_AXI_RREADY)
      rvalid_r <= 1'b0;
  end
endmodule
`default_nettype wire

// *** bench/wdt_checker_assertions.sv ***
// concurrent checks on the watchdog top ports
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
module wdt_checker
(
  input wire logic        REF_CLK,
  input wire logic        RESET_N,
  input wire logic        CLEAR_WDT_INSN,
  input wire logic        HALT_INSN,
  input wire logic        DEVICE_RESET_REQ,
  input wire logic        PC_SP_RESET,
  input wire logic        EXPIRY_FLAG,
  input wire logic [3:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY
);
  // one clock domain, so clocking and reset are given once
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESET_N);
  // reset requests are single-cycle pulses
  a_reset_pulse_one: assert property (DEVICE_RESET_REQ |=> !DEVICE_RESET_REQ)
    else $error("full reset request wider than one cycle");
  a_pcsp_pulse_one: assert property (PC_SP_RESET |=> !PC_SP_RESET)
    else $error("pc and sp reset wider than one cycle");
  // a sleeping overflow never asks for a full reset as well
  a_pulse_exclusive: assert property (!(PC_SP_RESET && DEVICE_RESET_REQ))
    else $error("both reset kinds at once");
  a_pcsp_sets_expiry: assert property (PC_SP_RESET |-> ##[0:1] EXPIRY_FLAG)
    else $error("sleep overflow without expiry flag");
  a_halt_clears_expiry: assert property (HALT_INSN |-> ##[1:2] !EXPIRY_FLAG)
    else $error("halt left expiry flag set");
  // a fresh clear cannot be followed by a sleep overflow within eight cycles
  a_clear_no_overflow: assert property (CLEAR_WDT_INSN |=> !PC_SP_RESET [*8])
    else $error("overflow right after clear");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  a_unmapped_read: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'h8
    |=> S_AXI_RRESP == `RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped before accept");
  // main scenarios reached
  c_full_reset: cover property (DEVICE_RESET_REQ);
  c_sleep_reset: cover property (PC_SP_RESET);
  c_slverr: cover property (S_AXI_RVALID && S_AXI_RRESP == `RESP_SLVERR);
endmodule
bind wdt_top wdt_checker u_chk (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .CLEAR_WDT_INSN(CLEAR_WDT_INSN),
  .HALT_INSN(HALT_INSN), .DEVICE_RESET_REQ(DEVICE_RESET_REQ), .PC_SP_RESET(PC_SP_RESET), .EXPIRY_FLAG(EXPIRY_FLAG),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
`default_nettype wire

// *** bench/test_watchdog_timer_with_guarded_enable.sv ***
// self-checking bench for the watchdog and its register port
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module test_watchdog_timer_with_guarded_enable
  import wdt_pkg::*;
;
  localparam int XD = 4;  // shortened crystal divider
  localparam int RD = 5;  // shortened rc divider
  logic        REF_CLK = 1'b0, RESET_N = 1'b0, SLOW_SRC_XTAL = 1'b1, CLEAR_WDT_INSN = 1'b0, WAKE = 1'b0;
  logic        HALT_INSN = 1'b0, HALT_DEEP = 1'b0, HALT_IDLE = 1'b0, S_AXI_BREADY = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_ARVALID = 1'b0;
  logic [3:0]  S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hF;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic        DEVICE_RESET_REQ, PC_SP_RESET, EXPIRY_FLAG, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID;
  logic [33:0] exp_q[$];  // expected {resp, data} of each read, oldest first
  logic [33:0] e_now;     // note taken off the queue
  int          num_errors = 0, checks = 0, cyc = 0, n_rst = 0, n_pcsp = 0;

  wdt_top #(.XTAL_DIV(XD), .RC_DIV(RD)) uut
  (
    .REF_CLK(REF_CLK), .RESET_N(RESET_N), .SLOW_SRC_XTAL(SLOW_SRC_XTAL), .CLEAR_WDT_INSN(CLEAR_WDT_INSN),
    .HALT_INSN(HALT_INSN), .HALT_DEEP(HALT_DEEP), .HALT_IDLE(HALT_IDLE), .WAKE(WAKE),
    .DEVICE_RESET_REQ(DEVICE_RESET_REQ), .PC_SP_RESET(PC_SP_RESET), .EXPIRY_FLAG(EXPIRY_FLAG),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
  );

  initial
    forever #2.5 REF_CLK = ~REF_CLK;

  // cycle count, pulse tallies and hang limit
  always @(posedge REF_CLK)
  begin
    cyc++;
    n_rst += DEVICE_RESET_REQ;
    n_pcsp += PC_SP_RESET;
    if (cyc == 40000)  // about twice the planned run
    begin
      num_errors++;
      complete_run();
    end
  end

  // read monitor: each answer against the oldest note
  always @(posedge REF_CLK)
    if (S_AXI_RVALID && S_AXI_RREADY)
    begin
      e_now = exp_q.pop_front();
      `CHK("read", e_now, {S_AXI_RRESP, S_AXI_RDATA})
    end

  // write: both channels offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge REF_CLK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_WSTRB <= {3'($urandom), 1'b1};  // only the low lane matters
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    while (!S_AXI_BVALID);
    S_AXI_BREADY <= 1'b0;
    `CHK("bresp", r, S_AXI_BRESP)
  endtask

  // read: note the expectation, the monitor compares
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do
    begin
      @(posedge REF_CLK);
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end
    while (!S_AXI_RVALID);
    S_AXI_RREADY <= 1'b0;
  endtask

  // one-cycle core pulse, k is {wake, halt, clear}
  task automatic pulse(input logic [2:0] k, input logic deep, input logic idle);
    @(posedge REF_CLK);
    {WAKE, HALT_INSN, CLEAR_WDT_INSN} <= k;
    HALT_DEEP <= deep;
    HALT_IDLE <= idle;
    @(posedge REF_CLK);
    {WAKE, HALT_INSN, CLEAR_WDT_INSN} <= 3'h0;
  endtask

  task automatic complete_run();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int          dv;   // slow divider in use
    int          lim;  // cycles to overflow
    logic [4:0]  bad;  // invalid enable code
    void'($urandom(9));
    repeat (8) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    rd(`ADDR_WATCHDOG_CONTROL, 34'h53);
    rd(`ADDR_RESET_CAUSE_FLAGS, 34'h0);
    rd(`ADDR_SLEEP_CONTROL, {`RESP_SLVERR, 32'h0});
    $display("test defaults done");
    // crystal with code 000, then rc with code 001
    for (int s = 1; s >= 0; s--)
    begin
      SLOW_SRC_XTAL <= s[0];
      dv = s ? XD : RD;
      lim = (s ? 256 : 1024) * dv;
      pulse(3'h1, 1'b0, 1'b0);
      wr(`ADDR_WATCHDOG_CONTROL, 32'h50 | {31'h0, ~s[0]}, `RESP_OKAY);
      repeat (3)
      begin
        repeat ($urandom_range(900, 100)) @(posedge REF_CLK);
        pulse(3'h1, 1'b0, 1'b0);
      end
      n_rst = 0;
      repeat (lim - 6 * dv) @(posedge REF_CLK);
      `CHK("early", 0, n_rst)
      `CHK("expiry early", ~s[0], EXPIRY_FLAG)
      repeat (12 * dv) @(posedge REF_CLK);
      `CHK("overflow", 1, n_rst)
      `CHK("expiry", 1'b1, EXPIRY_FLAG)
      $display("test overflow source %0d done", s);
    end
    wr(`ADDR_WATCHDOG_CONTROL, 32'hA8, `RESP_OKAY);
    n_rst = 0;
    repeat (1500) @(posedge REF_CLK);
    `CHK("disabled", 0, n_rst)
    do
      bad = 5'($urandom);
    while (bad == `GEN_DISABLE || bad == `GEN_ENABLE);
    n_rst = 0;
    wr(`ADDR_WATCHDOG_CONTROL, {24'h0, bad, 3'h0}, `RESP_OKAY);
    repeat (4 * RD) @(posedge REF_CLK);
    `CHK("bad code", 1'b1, n_rst > 0)
    wr(`ADDR_WATCHDOG_CONTROL, 32'h50, `RESP_OKAY);
    rd(`ADDR_RESET_CAUSE_FLAGS, 34'h1);
    wr(`ADDR_RESET_CAUSE_FLAGS, 32'h0, `RESP_OKAY);
    rd(`ADDR_RESET_CAUSE_FLAGS, 34'h0);
    $display("test enable codes done");
    // idle: overflow resets only pc and sp
    pulse(3'h2, 1'b0, 1'b1);
    n_rst = 0;
    n_pcsp = 0;
    @(negedge REF_CLK);  // the flag falls on the halt edge, so look once it has settled
    `CHK("expiry cleared", 1'b0, EXPIRY_FLAG)
    repeat (256 * RD + 60) @(posedge REF_CLK);
    `CHK("sleep overflow", 1, n_pcsp)
    `CHK("no full reset", 0, n_rst)
    // deepest sleep: counter stopped
    pulse(3'h2, 1'b1, 1'b0);
    n_pcsp = 0;
    repeat (3000) @(posedge REF_CLK);
    `CHK("deep stopped", 0, n_rst + n_pcsp)
    pulse(3'h4, 1'b0, 1'b0);
    // light sleep: counter cleared, keeps running, overflow resets only pc and sp
    pulse(3'h2, 1'b0, 1'b0);
    n_rst = 0;
    n_pcsp = 0;
    repeat (256 * RD + 60) @(posedge REF_CLK);
    `CHK("light overflow", 1, n_pcsp)
    `CHK("light no full reset", 0, n_rst)
    $display("test sleep modes done");
    complete_run();
  end
endmodule
`default_nettype wire
